// [eeprom_host_pkg.sv]
// Constants, register map and pin bundle of the parallel EEPROM host controller.
// Assumes a 20 MHz bus clock and one EEPROM with 15 address bits and 8 data bits.
package eeprom_host_pkg;

	// ----------------------------------------
	// Clock and pin timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROGRAM_TIME_MS = 10;
	localparam int LOAD_WINDOW_US = 100;
	localparam int BYTE_LOAD_MIN_NS = 300;
	localparam int BYTE_LOAD_MAX_US = 30;
	localparam int WE_PULSE_NS = 200;
	localparam int ACCESS_NS = 120;
	localparam int BUSY_DELAY_NS = 120;
	localparam int RELEASE_DELAY_NS = 600;
	localparam int SYNC_CYC = 2;
	localparam int PROG_WAIT_CYC = (PROGRAM_TIME_MS * 1000000) / CLK_PERIOD_NS + 1;
	localparam int LOAD_WIN_CYC = (LOAD_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLC_MIN_CYC = (BYTE_LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLC_MAX_CYC = (BYTE_LOAD_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int WP_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_DLY_CYC = (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_CYC = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BYTE_CYC = 8;
	localparam int WHIGH_CYC = BYTE_CYC - WP_CYC - 1;
	localparam int GAP_CYC = 2;
	localparam logic [6:0] PAGE_BYTES = 7'h40;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_ADDR = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_ISTAT = 8'h14;
	localparam logic [7:0] OFF_IMASK = 8'h18;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CFG_HOLD_BIT = 2;
	localparam int IRQ_WDONE_BIT = 0;
	localparam int IRQ_RDONE_BIT = 1;
	localparam int IRQ_REFUSE_BIT = 2;
	localparam logic [1:0] MODE_FIXED = 2'h0;
	localparam logic [1:0] MODE_POLL = 2'h1;
	localparam logic [1:0] MODE_PIN = 2'h2;
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// ----------------------------------------
	// Pin bundle
	// ----------------------------------------
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic hold_off_n;
		logic data_oe_n;
		logic [14:0] addr;
		logic [7:0] data;
	} pins_type;

	localparam pins_type PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hold_off_n: 1'b1,
		data_oe_n: 1'b1, addr: 15'h0000, data: 8'h00};

endpackage

// [page_ram.sv]
// Page buffer of 64 bytes with registered read data.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module page_ram (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [7:0] wdata,
	// Read port
	input wire logic [5:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:63];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// [eeprom_host.sv]
// Host controller that writes pages to and reads a byte-wide parallel EEPROM.
// Assumes an AHB-Lite master, a pull-up on the ready/busy line and the EEPROM data bus resolved outside.
//
// Functional notes
// RULE1: A page write carries 1 to 64 bytes, first byte plus up to 63.
// RULE2: Successive byte loads start 0.3 us to 30 us after the previous strobe fall.
// RULE3: Strobes stay high 100 us after the last byte so programming starts.
// RULE4: Page bits A6 to A14 are taken at the first strobe fall.
// RULE5: The device completes its program cycle by itself within 10 ms.
// RULE6: Without polling or ready/busy, wait beyond 10 ms before the next access.
// RULE7: With polling or ready/busy, restart as soon as completion shows.
// RULE8: During programming a read returns bit 7 inverted from the last written byte.
// RULE9: During programming bit 6 flips on each read, starting at 1.
// RULE10: At the end bit 6 stops flipping and the device accepts new operations.
// RULE11: Toggle polling reads keep one fixed address.
// RULE12: Ready/busy floats when idle, low from first write until program end.
// RULE13: Busy shows no sooner than 120 ns after the triggering write strobe.
// RULE14: While the hold-off input is low, reads and programming are refused.
// RULE15: Hold-off stays high through every read and program operation; a command in the cycle after a hold-bit write runs with hold-off low.
// RULE16: Data floats 350 ns after hold-off falls; valid 600 ns after release.
// RULE17: Address taken on strobe fall, data on strobe rise of the later strobe.
// RULE18: Hold-off falling during programming aborts it; keep high 10 ms after data.
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host #(
	parameter int PROG_WAIT = eeprom_host_pkg::PROG_WAIT_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Interrupt
	output logic irq,
	// EEPROM pins
	output eeprom_host_pkg::pins_type pins,
	input wire logic [7:0] data_in,
	input wire logic rdy_busy_in
);
	import eeprom_host_pkg::*;

	typedef enum logic [9:0] {
		S_IDLE = 10'b0000000001, S_WSET = 10'b0000000010, S_WLOW = 10'b0000000100,
		S_WHIGH = 10'b0000001000, S_WIN = 10'b0000010000, S_PIN = 10'b0000100000,
		S_PRD = 10'b0001000000, S_PGAP = 10'b0010000000, S_FIX = 10'b0100000000,
		S_RD = 10'b1000000000
	} state_type;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic [17:0] tload(input state_type s);
		case (s)
			S_WLOW: return 18'(WP_CYC - 1);
			S_WHIGH: return 18'(WHIGH_CYC - 1);
			S_WIN: return 18'(LOAD_WIN_CYC - 1);
			S_PIN: return 18'(BUSY_DLY_CYC + SYNC_CYC);
			S_PRD, S_RD: return 18'(ACC_CYC + SYNC_CYC);
			S_PGAP: return 18'(GAP_CYC - 1);
			default: return 18'h00000;
		endcase
	endfunction

	state_type state_reg, state_next;
	logic [17:0] tmr_reg, guard_reg;
	logic [6:0] idx_reg, len_reg, fill_reg, rel_reg;
	logic [14:0] addr_reg;
	logic [2:0] cfg_reg, istat_reg, imask_reg, iset;
	logic [7:0] rd_data_reg, ram_rdata, d1_reg, d2_reg;
	logic r1_reg, r2_reg, hold_on_reg, hold_apply, prev_tog_reg, one_reg, two_reg, bit7_reg;
	logic ph_wr_reg, hreadyout_reg, wr_fire, cmd_w, cmd_r, ready_ok, start_w, start_r, dat_we;
	logic tdone, poll_match;
	logic [5:0] cur_idx;
	logic [7:0] ph_addr_reg;
	logic [31:0] hrdata_reg, rd_word;
	pins_type pins_reg;

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign pins = pins_reg;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d1_reg <= 8'h00;
			d2_reg <= 8'h00;
			r1_reg <= 1'b1;
			r2_reg <= 1'b1;
		end else begin
			d1_reg <= data_in;
			d2_reg <= d1_reg;
			r1_reg <= rdy_busy_in;
			r2_reg <= r1_reg;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_reg <= 1'b0;
			ph_addr_reg <= 8'h00;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h00000000;
		end else begin
			if (hready) begin
				ph_wr_reg <= hsel && htrans[1] && hwrite;
				ph_addr_reg <= haddr[7:0];
			end
			hreadyout_reg <= !(hready && hsel && htrans[1] && !hwrite);
			if (!hreadyout_reg) begin
				hrdata_reg <= rd_word;
			end
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (hit(ph_addr_reg, OFF_CFG)) rd_word = {29'h0, cfg_reg};
		if (hit(ph_addr_reg, OFF_ADDR)) rd_word = {17'h0, addr_reg};
		if (hit(ph_addr_reg, OFF_DATA)) rd_word = {24'h0, rd_data_reg};
		if (hit(ph_addr_reg, OFF_STATUS)) rd_word = {17'h0, fill_reg, 5'h0, r2_reg, hold_on_reg, state_reg != S_IDLE};
		if (hit(ph_addr_reg, OFF_ISTAT)) rd_word = {29'h0, istat_reg};
		if (hit(ph_addr_reg, OFF_IMASK)) rd_word = {29'h0, imask_reg};
	end

	assign wr_fire = ph_wr_reg && hready;
	assign cmd_w = wr_fire && hit(ph_addr_reg, OFF_CMD) && hwdata[CMD_WRITE_BIT];
	assign cmd_r = wr_fire && hit(ph_addr_reg, OFF_CMD) && hwdata[CMD_READ_BIT];
	assign ready_ok = state_reg == S_IDLE && !hold_on_reg && rel_reg == 7'h00; // see RULE14
	assign start_w = cmd_w && ready_ok && fill_reg != 7'h00; // see RULE1
	assign start_r = cmd_r && !cmd_w && ready_ok;
	assign dat_we = wr_fire && hit(ph_addr_reg, OFF_DATA) && state_reg == S_IDLE && fill_reg != PAGE_BYTES;
	assign cur_idx = start_w ? 6'h00 : idx_reg[5:0]; // see RULE17

	page_ram u_ram (
		.clk(hclk),
		.we(dat_we),
		.waddr(fill_reg[5:0]),
		.wdata(hwdata[7:0]),
		.raddr(cur_idx),
		.rdata(ram_rdata)
	);

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= CFG_RST;
			addr_reg <= 15'h0000;
			imask_reg <= IRQ_RST;
			fill_reg <= 7'h00;
		end else begin
			if (wr_fire && hit(ph_addr_reg, OFF_CFG)) cfg_reg <= hwdata[2:0];
			if (wr_fire && hit(ph_addr_reg, OFF_ADDR) && state_reg == S_IDLE) addr_reg <= hwdata[14:0];
			if (wr_fire && hit(ph_addr_reg, OFF_IMASK)) imask_reg <= hwdata[2:0];
			if (start_w) fill_reg <= 7'h00;
			else if (dat_we) fill_reg <= fill_reg + 7'h01;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_comb begin
		iset = 3'h0;
		iset[IRQ_WDONE_BIT] = (state_reg == S_PIN || state_reg == S_PGAP || state_reg == S_FIX) && state_next == S_IDLE;
		iset[IRQ_RDONE_BIT] = state_reg == S_RD && state_next == S_IDLE;
		iset[IRQ_REFUSE_BIT] = (cmd_w || cmd_r) && !(start_w || start_r);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_reg <= IRQ_RST;
			irq <= 1'b0;
		end else begin
			if (wr_fire && hit(ph_addr_reg, OFF_ISTAT)) istat_reg <= (istat_reg & ~hwdata[2:0]) | iset;
			else istat_reg <= istat_reg | iset;
			irq <= |(istat_reg & imask_reg);
		end
	end

	// ----------------------------------------
	// Transfer sequencer
	// ----------------------------------------
	assign tdone = tmr_reg == 18'h00000;
	assign poll_match = two_reg && rd_data_reg[6] == prev_tog_reg && rd_data_reg[7] == bit7_reg; // see RULE8 RULE9 RULE10

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (start_w) state_next = S_WSET;
				else if (start_r) state_next = S_RD;
			end
			S_WSET: state_next = S_WLOW;
			S_WLOW: if (tdone) state_next = S_WHIGH;
			S_WHIGH: if (tdone) state_next = (idx_reg == len_reg) ? S_WIN : S_WSET; // see RULE2
			S_WIN: begin
				if (tdone) begin // see RULE3
					case (cfg_reg[1:0])
						MODE_PIN: state_next = S_PIN;
						MODE_POLL: state_next = S_PRD;
						default: state_next = S_FIX;
					endcase
				end
			end
			S_PIN: if (tdone && r2_reg) state_next = S_IDLE; // see RULE12 RULE13 RULE7
			S_PRD: if (tdone) state_next = S_PGAP;
			S_PGAP: if (tdone) state_next = poll_match ? S_IDLE : S_PRD; // see RULE7
			S_FIX: if (guard_reg == 18'h00000) state_next = S_IDLE; // see RULE6 RULE5
			S_RD: if (tdone) state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			tmr_reg <= 18'h00000;
			idx_reg <= 7'h00;
			len_reg <= 7'h00;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) tmr_reg <= tload(state_next);
			else if (!tdone) tmr_reg <= tmr_reg - 18'h00001;
			if (start_w) begin
				idx_reg <= 7'h00;
				len_reg <= fill_reg;
			end else if (state_reg == S_WLOW && tdone) begin
				idx_reg <= idx_reg + 7'h01;
			end
		end
	end

	// Program guard: counts from each data input, blocks hold-off and ends a fixed wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			guard_reg <= 18'h00000;
		end else if (state_reg == S_WLOW && tdone) begin
			guard_reg <= 18'(PROG_WAIT); // see RULE18 RULE6
		end else if (guard_reg != 18'h00000) begin
			guard_reg <= guard_reg - 18'h00001;
		end
	end

	// Read capture and toggle tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data_reg <= 8'h00;
			prev_tog_reg <= 1'b0;
			one_reg <= 1'b0;
			two_reg <= 1'b0;
			bit7_reg <= 1'b0;
		end else begin
			if (state_reg == S_WSET) bit7_reg <= ram_rdata[7];
			if (state_reg == S_WIN) begin
				one_reg <= 1'b0;
				two_reg <= 1'b0;
			end else if ((state_reg == S_PRD || state_reg == S_RD) && tdone) begin
				rd_data_reg <= d2_reg;
				prev_tog_reg <= rd_data_reg[6];
				one_reg <= 1'b1;
				two_reg <= one_reg;
			end
		end
	end

	// ----------------------------------------
	// Hold-off control
	// ----------------------------------------
	assign hold_apply = state_reg == S_IDLE && guard_reg == 18'h00000; // see RULE15 RULE18

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_on_reg <= 1'b0;
			rel_reg <= 7'h00;
		end else begin
			if (hold_apply) hold_on_reg <= cfg_reg[CFG_HOLD_BIT];
			if (hold_apply && hold_on_reg && !cfg_reg[CFG_HOLD_BIT]) rel_reg <= 7'(REL_CYC); // see RULE16
			else if (rel_reg != 7'h00) rel_reg <= rel_reg - 7'h01;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_reg <= PINS_RST;
		end else begin
			pins_reg.ce_n <= !(state_next == S_WSET || state_next == S_WLOW || state_next == S_PRD || state_next == S_RD);
			pins_reg.oe_n <= !(state_next == S_PRD || state_next == S_RD);
			pins_reg.we_n <= state_next != S_WLOW;
			pins_reg.data_oe_n <= !(state_next == S_WLOW || state_reg == S_WLOW);
			pins_reg.hold_off_n <= hold_apply ? !cfg_reg[CFG_HOLD_BIT] : !hold_on_reg;
			if (state_next == S_WSET) pins_reg.addr <= {addr_reg[14:6], addr_reg[5:0] + cur_idx}; // see RULE4 RULE17
			else if (state_next == S_PRD || state_next == S_RD) pins_reg.addr <= addr_reg; // see RULE11
			if (state_next == S_WLOW && state_reg == S_WSET) pins_reg.data <= ram_rdata; // see RULE17
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_strobe;
		$fell(pins_reg.we_n) ##0 !pins_reg.ce_n;
	endsequence
	sequence s_poll_done;
		state_reg == S_PGAP && tdone && poll_match;
	endsequence

	a_we_width: assert property (s_strobe |-> (!pins_reg.we_n)[*4] ##1 pins_reg.we_n) // see RULE17
		else $error("write strobe width wrong");
	a_load_min_gap: assert property ($fell(pins_reg.we_n) |=> (!$fell(pins_reg.we_n))[*5]) // see RULE2
		else $error("byte loads too close");
	a_load_max_gap: assert property ($fell(pins_reg.we_n) |-> ##[1:600] ($fell(pins_reg.we_n) || state_reg == S_WIN)) // see RULE2
		else $error("byte load window exceeded");
	a_page_bits: assert property ($fell(pins_reg.we_n) |-> pins_reg.addr[14:6] == addr_reg[14:6]) // see RULE4
		else $error("page bits changed within page");
	a_window_quiet: assert property (state_reg == S_WIN |-> pins_reg.we_n && pins_reg.ce_n) // see RULE3
		else $error("strobe active in load window");
	a_byte_count: assert property ($rose(state_reg == S_WIN) |-> idx_reg == len_reg && len_reg <= PAGE_BYTES) // see RULE1
		else $error("page byte count wrong");
	a_hold_in_op: assert property (!pins_reg.ce_n |-> pins_reg.hold_off_n) // see RULE15
		else $error("hold-off low during access");
	a_hold_guard: assert property ($fell(pins_reg.hold_off_n) |-> $past(guard_reg) == 18'h00000) // see RULE18
		else $error("hold-off asserted during program time");
	a_fixed_wait: assert property (state_reg == S_FIX && guard_reg != 18'h00000 |=> state_reg == S_FIX) // see RULE6
		else $error("fixed wait left early");
	a_poll_addr: assert property (state_reg == S_PRD |-> pins_reg.addr == addr_reg) // see RULE11
		else $error("poll address moved");
	a_poll_restart: assert property (s_poll_done |=> state_reg == S_IDLE) // see RULE7
		else $error("poll completion not taken");
	a_pin_busy: assert property (state_reg == S_PIN && !r2_reg |=> state_reg == S_PIN) // see RULE12
		else $error("left ready wait while busy");
endmodule
`default_nettype wire

// [eeprom_model.sv]
// Behavioural model of the byte-wide EEPROM that faces the host controller.
// Assumes the bench resolves the shared data bus and the open-drain ready/busy line.
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
	parameter int PROG_NS = 20000,
	parameter int LOAD_NS = 100000
) (
	// Control pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hold_off_n,
	// Address and data
	input wire logic [14:0] addr,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe_n,
	// Ready/busy and state
	output logic rdy_oe_n,
	output logic busy
);
	logic [7:0] mem [0:32767];
	logic [7:0] pbuf [0:63];
	logic [63:0] loaded = '0;
	logic [8:0] page = '0;
	logic [5:0] wa = '0;
	logic [7:0] last = '0;
	logic loading = 1'b0;
	logic prog = 1'b0;
	logic tog = 1'b1;
	logic rel_ok = 1'b1;
	realtime t_ref = 0;
	wire logic strobe_n;
	wire logic read_n;
	assign strobe_n = ce_n | we_n;
	assign read_n = ce_n | oe_n;
	assign busy = loading | prog;
	assign dq_oe_n = read_n | !we_n | !hold_off_n | !rel_ok;
	assign dq_out = busy ? {~last[7], tog, last[5:0]} : mem[addr];
	initial begin
		rdy_oe_n = 1'b1;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// ----------------------------------------
	// Byte loads
	// ----------------------------------------
	always @(negedge strobe_n) begin
		if (hold_off_n && !prog) begin
			if (!loading) begin
				page = addr[14:6];
				loaded = '0;
				tog = 1'b1;
				loading = 1'b1;
			end
			wa = addr[5:0];
			t_ref = $realtime;
		end
	end
	always @(posedge strobe_n) begin
		if (hold_off_n && loading) begin
			pbuf[wa] = dq_in;
			loaded[wa] = 1'b1;
			last = dq_in;
			t_ref = $realtime;
		end
	end
	// ----------------------------------------
	// Load window and program cycle
	// ----------------------------------------
	always begin
		#50;
		if (loading && strobe_n && $realtime - t_ref >= LOAD_NS) begin
			loading = 1'b0;
			prog = 1'b1;
			t_ref = $realtime;
		end else if (prog && $realtime - t_ref >= PROG_NS) begin
			for (int i = 0; i < 64; i++) begin
				if (loaded[i]) mem[{page, i[5:0]}] = pbuf[i];
			end
			prog = 1'b0;
		end
	end
	always @(posedge busy) begin
		#120;
		rdy_oe_n = !busy;
	end
	always @(negedge busy) rdy_oe_n = 1'b1;
	always @(posedge read_n) if (busy && we_n && hold_off_n) tog = ~tog;
	// ----------------------------------------
	// Hold-off input
	// ----------------------------------------
	always @(negedge hold_off_n) begin
		if (prog) begin
			for (int i = 0; i < 64; i++) begin
				if (loaded[i]) mem[{page, i[5:0]}] = ~pbuf[i];
			end
		end
		loading = 1'b0;
		prog = 1'b0;
		rel_ok = 1'b0;
	end
	always @(posedge hold_off_n) begin
		#600;
		rel_ok = hold_off_n;
	end
endmodule
`default_nettype wire

// [eeprom_host_bench.sv]
// Self-checking bench of the EEPROM host controller against the device model.
// Assumes the shortened fixed wait exceeds the model's load window plus program time.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_bench;
	import eeprom_host_pkg::*;
	localparam int PW = 2600;
	typedef struct {logic [1:0] mode; int n; logic [14:0] a; logic [7:0] d0; logic fast;} row_type;
	row_type rows [4] = '{'{MODE_FIXED, 1, 15'h0000, 8'h81, 1'b0}, '{MODE_POLL, 64, 15'h7fc0, 8'h00, 1'b1},
		'{MODE_PIN, 3, 15'h12fe, 8'h7e, 1'b1}, '{2'h3, 2, 15'h0040, 8'hf0, 1'b0}};
	logic [7:0] regs [4] = '{OFF_CFG, OFF_IMASK, OFF_ISTAT, 8'h1c};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rv;
	logic hreadyout, hresp, irq, rdy_oe_n, dq_oe_n, busy_m;
	logic [7:0] dq_out;
	logic [7:0] bus_q = 8'h00;
	pins_type pins;
	wire logic [7:0] data_in;
	int error_cnt = 0;
	int n_compared = 0;
	int c;
	logic [1:0] cur_mode = 2'h0;
	logic [14:0] poll_addr = '0;
	logic poll_seen = 1'b0;
	realtime t_fall = 0;
	always #25 hclk = ~hclk;
	// Released data bus shows the inverse of its last level
	assign data_in = !pins.data_oe_n ? pins.data : (!dq_oe_n ? dq_out : ~bus_q);
	always @(posedge hclk) bus_q <= data_in;
	// Pull-up on ready/busy: line is low only while the model drives it
	eeprom_host #(.PROG_WAIT(PW)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pins(pins),
		.data_in(data_in), .rdy_busy_in(rdy_oe_n));
	eeprom_model mdl (.ce_n(pins.ce_n), .oe_n(pins.oe_n), .we_n(pins.we_n), .hold_off_n(pins.hold_off_n),
		.addr(pins.addr), .dq_in(data_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .rdy_oe_n(rdy_oe_n),
		.busy(busy_m));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int k;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		for (int p = 0; p < 2; p++) begin
			k = 0;
			do begin
				@(posedge hclk);
				k++;
			end while (hreadyout !== 1'b1 && k < 50);
			if (k >= 50) begin
				error_cnt++;
				conclude();
			end
			if (p == 0) begin
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
		rv = hrdata;
	endtask
	task automatic wait_for(input logic hold);
		c = 0;
		while ((hold ? pins.hold_off_n !== 1'b0 : irq !== 1'b1) && c < 20000) begin
			@(posedge hclk);
			c++;
		end
		if (c >= 20000) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic page_case(input row_type r);
		logic [14:0] ea;
		cur_mode = r.mode;
		ahb(1'b1, OFF_CFG, {30'h0, r.mode});
		ahb(1'b1, OFF_IMASK, 32'h3);
		ahb(1'b1, OFF_ADDR, {17'h0, r.a});
		for (int i = 0; i < r.n; i++) ahb(1'b1, OFF_DATA, {24'h0, r.d0 + 8'(i)});
		ahb(1'b0, OFF_STATUS, 32'h0);
		chk(rv[14:8], r.n);
		ahb(1'b1, OFF_CMD, 32'h1);
		wait_for(1'b0);
		chk(c > r.n * 8 + PW - 50, !r.fast);
		ahb(1'b0, OFF_ISTAT, 32'h0);
		chk(rv, 32'h1);
		ahb(1'b1, OFF_ISTAT, 32'h1);
		for (int j = 0; j < r.n; j++) begin
			ea = {r.a[14:6], r.a[5:0] + 6'(j)};
			ahb(1'b1, OFF_ADDR, {17'h0, ea});
			ahb(1'b1, OFF_CMD, 32'h2);
			wait_for(1'b0);
			ahb(1'b0, OFF_DATA, 32'h0);
			chk(rv[7:0], 8'(r.d0 + 8'(j)));
			ahb(1'b1, OFF_ISTAT, 32'h3);
		end
	endtask
	// ----------------------------------------
	// Pin monitors
	// ----------------------------------------
	always @(negedge pins.we_n) begin
		if (t_fall > 0 && $realtime - t_fall < 100000) chk($realtime - t_fall >= 300 && $realtime - t_fall <= 30000, 1);
		t_fall = $realtime;
	end
	always @(negedge pins.oe_n) begin
		if (cur_mode != MODE_POLL) chk(busy_m, 0);
		if (busy_m && poll_seen) chk(pins.addr, poll_addr);
		poll_seen = busy_m;
		poll_addr = pins.addr;
	end
	always @(negedge pins.hold_off_n) chk({busy_m, pins.ce_n}, 2'b01);
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) page_case(rows[i]);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk(pins, PINS_RST);
		chk({hreadyout, irq, hresp}, 3'b100);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, 8'h1c, 32'hffff_ffff);
		foreach (regs[i]) begin
			ahb(1'b0, regs[i], 32'h0);
			chk(rv, 32'h0);
		end
		// Refused command, masked then unmasked interrupt
		ahb(1'b1, OFF_CMD, 32'h1);
		ahb(1'b0, OFF_ISTAT, 32'h0);
		chk({rv[30:0], irq}, 32'h8);
		ahb(1'b1, OFF_IMASK, 32'h7);
		repeat (2) @(posedge hclk);
		chk(irq, 1);
		ahb(1'b1, OFF_ISTAT, 32'h4);
		repeat (2) @(posedge hclk);
		chk(irq, 0);
		// Hold request during a program cycle is deferred
		cur_mode = MODE_POLL;
		ahb(1'b1, OFF_ADDR, 32'h0100);
		ahb(1'b1, OFF_DATA, 32'h5a);
		ahb(1'b1, OFF_CMD, 32'h1);
		ahb(1'b1, OFF_CFG, 32'h5);
		wait_for(1'b0);
		wait_for(1'b1);
		ahb(1'b1, OFF_ISTAT, 32'h7);
		ahb(1'b1, OFF_CMD, 32'h2);
		ahb(1'b0, OFF_ISTAT, 32'h0);
		chk(rv, 32'h4);
		ahb(1'b1, OFF_ISTAT, 32'h7);
		ahb(1'b1, OFF_CFG, 32'h1);
		ahb(1'b1, OFF_CMD, 32'h2);
		ahb(1'b0, OFF_ISTAT, 32'h0);
		chk(rv, 32'h4);
		ahb(1'b1, OFF_ISTAT, 32'h7);
		repeat (20) @(posedge hclk);
		ahb(1'b1, OFF_CMD, 32'h2);
		wait_for(1'b0);
		ahb(1'b0, OFF_DATA, 32'h0);
		chk(rv, 32'h5a);
		conclude();
	end
endmodule
`default_nettype wire
